// ===== shared/pmv_pkg.sv
// package: power control map, interrupt ordering and vector table
package pmv_pkg;
  localparam logic [7:0] POWER_CONTROL_ADDR       = 8'h87;
  localparam logic [7:0] POWER_CONTROL_RESET      = 8'h00;
  localparam int         BIT_BAUD_DBL    = 7;
  localparam int         BIT_AUX_RAM_OFF = 6;
  localparam int         BIT_STROBE_QUIET= 5;
  localparam int         BIT_WDOG_PERMIT = 4;
  localparam int         BIT_USER_B      = 3;
  localparam int         BIT_USER_A      = 2;
  localparam int         BIT_DEEP_SLEEP  = 1;
  localparam int         BIT_SLEEP       = 0;
  localparam int         NSRC            = 15;
  // source index = vector order; vector = 0x0003 + 8*index
  localparam logic [15:0] VEC_BASE       = 16'h0003;
  localparam logic [15:0] VEC_STEP       = 16'h0008;
  localparam int SRC_EXT_A = 0;
  localparam int SRC_T0    = 1;
  localparam int SRC_EXT_B = 2;
  localparam int SRC_T1    = 3;
  localparam int SRC_UART  = 4;
  localparam int SRC_IIC   = 5;
  localparam int SRC_CAP0  = 6;
  localparam int SRC_CAP1  = 7;
  localparam int SRC_CAP2  = 8;
  localparam int SRC_CAP3  = 9;
  localparam int SRC_ADC   = 10;
  localparam int SRC_CMP0  = 11;
  localparam int SRC_CMP1  = 12;
  localparam int SRC_CMP2  = 13;
  localparam int SRC_T2    = 14;
  // sources able to end idle
  localparam logic [14:0] IDLE_WAKE_MASK = 15'h003f;
  // sources able to end power-down (ext_a, ext_b/tick)
  localparam logic [14:0] DEEP_WAKE_MASK = 15'h0005;
  // watchdog reset restart delay in machine cycles, 12 clocks each
  localparam int WDOG_RESTART_MC  = 3;
  localparam int CLKS_PER_MC      = 12;
  localparam logic [7:0] WDOG_RESTART_CLKS = 8'(WDOG_RESTART_MC * CLKS_PER_MC);
  // external reset minimum in idle, HF oscillator
  localparam int EXT_RESET_MIN_CLKS = 24;
  // APB offsets of control registers
  localparam logic [11:0] OFF_CMD    = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_VECTOR = 12'h008;
  localparam logic [11:0] OFF_SRC    = 12'h00c;
  typedef enum logic [2:0] {
    PMV_RUN  = 3'b001,
    PMV_IDLE = 3'b010,
    PMV_DEEP = 3'b100
  } pmv_mode_t;
endpackage

// ===== shared/pmv_if.sv
// interface: cpu/sfr side of the power-mode block
`timescale 1ns/1ps
`default_nettype none
interface pmv_if (input wire logic pclk, input wire logic presetn);
  logic        sfr_wr;
  logic [7:0]  sfr_addr;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic        wdog_loaded;
  logic [14:0] irq_req;
  logic [14:0] irq_level;
  logic        in_service;
  logic        in_service_level;
  logic        irq_take;
  logic [3:0]  irq_src;
  logic [15:0] irq_vector;
  logic        cpu_halt;
  modport device (input sfr_wr, sfr_addr, sfr_wdata, wdog_loaded, irq_req, irq_level,
                  in_service, in_service_level, output sfr_rdata, irq_take, irq_src,
                  irq_vector, cpu_halt);
  modport host (output sfr_wr, sfr_addr, sfr_wdata, wdog_loaded, irq_req, irq_level,
                in_service, in_service_level, input sfr_rdata, irq_take, irq_src,
                irq_vector, cpu_halt);
endinterface
`default_nettype wire

// ===== verilog/pmv_arbiter.sv
// fixed-order interrupt arbiter with vector lookup
`timescale 1ns/1ps
`default_nettype none
module pmv_arbiter (
  input  wire logic [14:0] req,
  output logic             any,
  output logic [3:0]       src,
  output logic [15:0]      vector
);
  // polling order, highest first, as vector-order indices
  localparam logic [3:0] ORDER [15] = '{4'd0, 4'd5, 4'd10, 4'd1, 4'd6, 4'd11, 4'd2,
                                        4'd7, 4'd12, 4'd3, 4'd8, 4'd13, 4'd4, 4'd9, 4'd14};
  always_comb begin
    any = 1'b0;
    src = 4'h0;
    for (int i = pmv_pkg::NSRC - 1; i >= 0; i--) begin // R1
      if (req[ORDER[i]]) begin
        any = 1'b1;
        src = ORDER[i];
      end
    end
    vector = pmv_pkg::VEC_BASE + 16'(src) * pmv_pkg::VEC_STEP; // R2
  end
endmodule // pmv_arbiter
`default_nettype wire

// ===== verilog/pmv_device.sv
// device end: power control register, mode sequencer, pins, vectoring
// What this block does
// (R1) fixed priority order among fifteen sources
// (R2) vectors from 0003h spaced eight bytes
// (R3) bit7 doubles baud, bit6 disables aux RAM
// (R4) bit5 silences address latch strobe
// (R5) load permit set by software, auto-cleared
// (R6) power-down accepted only with watchdog_off_pin high
// (R7) sleep_request write enters idle after instruction
// (R8) idle halts CPU, resets timer2, PWM, ADC
// (R9) idle keeps timers, serial, tick running
// (R10) power-down stops clocks, slow osc optional
// (R11) register at 87h, byte access, resets zero
// (R12) enabled early sources clear idle bit
// (R13) resume after the entering instruction
// (R14) external reset held 24 periods in idle
// (R15) PLL reset 1us..10ms, restart about 63ms
// (R16) watchdog reset ends idle, restart 3 cycles
// (R17) strobes high idle, low power-down
// (R18) iic pins float in power-down
// (R19) no power-down while watchdog enabled
// (R20) power-down ends on reset or wake pins
// (R21) busy same priority moves power-down to idle
// (R22) wake pins level-sensitive, held low
// (R23) keep_slow_osc keeps 32k oscillator in power-down
// (R24) asynchronous wake combine then synchronize
`timescale 1ns/1ps
`default_nettype none
module pmv_device (
  pmv_if.device       bus,
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   watchdog_off_pin,
  input  wire logic   wdog_reset,
  input  wire logic   osc_source_select,
  input  wire logic   keep_slow_osc,
  input  wire logic   iic_port_on,
  input  wire logic   ext_mem,
  input  wire logic   ext_a_pin,
  input  wire logic   ext_b_pin,
  input  wire logic   ext_a_level,
  input  wire logic   ext_b_level,
  input  wire logic   ext_a_en,
  input  wire logic   ext_b_en,
  input  wire logic   tick_req,
  output logic        baud_doubler,
  output logic        aux_ram_off,
  output logic        ale_run,
  output logic        ale_level,
  output logic        prog_store_strobe,
  output logic        port0_float,
  output logic        port2_addr,
  output logic        timer2_clear,
  output logic        pwm_force_high,
  output logic        adc_abort,
  output logic        sys_clk_run,
  output logic        hf_osc_run,
  output logic        slow_osc_run,
  output logic        iic_pins_allow,
  output logic        restart_hold,
  output logic        osc_wake
);
  typedef struct packed {
    logic [7:0]          power_control;
    pmv_pkg::pmv_mode_t  mode;
    logic [7:0]          wdog_cnt;
    logic                wake_s1;
    logic                wake_s2;
    logic                take;
    logic [3:0]          src;
    logic [15:0]         vec;
    logic [7:0]          rdata;
    logic                halt;
    logic [15:0]         pins;
  } pmv_dev_st_t;

  pmv_dev_st_t st_r;
  pmv_dev_st_t st_nxt;
  logic        arb_any;
  logic [3:0]  arb_src;
  logic [15:0] arb_vec;
  logic [14:0] pending;
  logic [14:0] pending_hi;
  logic [14:0] arb_req;
  logic [14:0] idle_wake;
  logic        deep_wake_a;
  logic        deep_wake_b;
  logic        deep_wake_async;
  logic        idle_blocked;

  pmv_arbiter u_arb (
    .req    (arb_req),
    .any    (arb_any),
    .src    (arb_src),
    .vector (arb_vec)
  );

  // only sources above the in-service level may be taken
  always_comb begin
    for (int i = 0; i < pmv_pkg::NSRC; i++) begin
      pending[i] = bus.irq_req[i] & ~(bus.in_service &
                   (bus.in_service_level >= bus.irq_level[i])); // R12 R21
    end
  end
  // a level-one request outranks every level-zero request; order applies within a level
  assign pending_hi = pending & bus.irq_level;
  assign arb_req    = (|pending_hi) ? pending_hi : pending; // R1
  assign idle_wake = pending & pmv_pkg::IDLE_WAKE_MASK; // R12
  // combined without clock so a stopped oscillator can be restarted
  assign deep_wake_a = ext_a_en & ext_a_level & ~ext_a_pin;
  assign deep_wake_b = ext_b_en & ext_b_level & (~ext_b_pin | tick_req);
  assign deep_wake_async = deep_wake_a | deep_wake_b; // R24 R22 R20
  // the waking pin is still held low here, so its own priority level decides
  assign idle_blocked = bus.in_service & ~(~bus.in_service_level &
                        ((deep_wake_a & bus.irq_level[pmv_pkg::SRC_EXT_A]) |
                         (deep_wake_b & bus.irq_level[pmv_pkg::SRC_EXT_B]))); // R21

  always_comb begin
    st_nxt = st_r;
    st_nxt.take = 1'b0;
    st_nxt.wake_s1 = deep_wake_async; // R24
    st_nxt.wake_s2 = st_r.wake_s1;
    if (st_r.wdog_cnt != 8'h00) begin
      st_nxt.wdog_cnt = st_r.wdog_cnt - 8'h01;
    end
    // byte-wide access only, no bit addressing
    if (bus.sfr_wr && bus.sfr_addr == pmv_pkg::POWER_CONTROL_ADDR) begin // R11
      st_nxt.power_control = bus.sfr_wdata;
      st_nxt.power_control[pmv_pkg::BIT_DEEP_SLEEP] = bus.sfr_wdata[pmv_pkg::BIT_DEEP_SLEEP] &
                                             watchdog_off_pin; // R6 R19
    end
    if (bus.wdog_loaded) begin
      st_nxt.power_control[pmv_pkg::BIT_WDOG_PERMIT] = 1'b0; // R5
    end
    unique case (st_r.mode)
      pmv_pkg::PMV_RUN: begin
        if (st_r.power_control[pmv_pkg::BIT_DEEP_SLEEP]) begin
          st_nxt.mode = pmv_pkg::PMV_DEEP; // R6
        end else if (st_r.power_control[pmv_pkg::BIT_SLEEP]) begin
          st_nxt.mode = pmv_pkg::PMV_IDLE; // R7
        end else if (arb_any) begin
          st_nxt.take = 1'b1;
          st_nxt.src  = arb_src;
          st_nxt.vec  = arb_vec;
        end
      end
      pmv_pkg::PMV_IDLE: begin
        if (|idle_wake) begin
          st_nxt.power_control[pmv_pkg::BIT_SLEEP] = 1'b0; // R12
          st_nxt.mode = pmv_pkg::PMV_RUN; // R13
        end
      end
      pmv_pkg::PMV_DEEP: begin
        if (st_r.wake_s2) begin
          st_nxt.power_control[pmv_pkg::BIT_DEEP_SLEEP] = 1'b0; // R24
          if (idle_blocked) begin
            st_nxt.power_control[pmv_pkg::BIT_SLEEP] = 1'b1;
            st_nxt.mode = pmv_pkg::PMV_IDLE; // R21
          end else begin
            st_nxt.mode = pmv_pkg::PMV_RUN; // R20 R13
          end
        end
      end
    endcase
    // watchdog reset ends idle; core held for three machine cycles
    if (wdog_reset) begin
      st_nxt.power_control = pmv_pkg::POWER_CONTROL_RESET;
      st_nxt.mode = pmv_pkg::PMV_RUN;
      st_nxt.wdog_cnt = pmv_pkg::WDOG_RESTART_CLKS; // R16
    end
    st_nxt.halt = (st_nxt.mode != pmv_pkg::PMV_RUN) | (st_nxt.wdog_cnt != 8'h00); // R8
    st_nxt.rdata = (bus.sfr_addr == pmv_pkg::POWER_CONTROL_ADDR) ? st_nxt.power_control : 8'h00;
    st_nxt.pins[0]  = st_nxt.power_control[pmv_pkg::BIT_BAUD_DBL]; // R3
    st_nxt.pins[1]  = st_nxt.power_control[pmv_pkg::BIT_AUX_RAM_OFF]; // R3
    st_nxt.pins[2]  = ~st_nxt.power_control[pmv_pkg::BIT_STROBE_QUIET] &
                      (st_nxt.mode == pmv_pkg::PMV_RUN); // R4
    st_nxt.pins[3]  = (st_nxt.mode == pmv_pkg::PMV_IDLE); // R17
    st_nxt.pins[4]  = (st_nxt.mode != pmv_pkg::PMV_DEEP); // R17
    st_nxt.pins[5]  = ext_mem & (st_nxt.mode != pmv_pkg::PMV_RUN); // R17
    st_nxt.pins[6]  = ext_mem & (st_nxt.mode == pmv_pkg::PMV_IDLE); // R17
    st_nxt.pins[7]  = (st_nxt.mode == pmv_pkg::PMV_IDLE); // R8
    st_nxt.pins[8]  = (st_nxt.mode != pmv_pkg::PMV_RUN); // R8 R17
    st_nxt.pins[9]  = (st_nxt.mode == pmv_pkg::PMV_IDLE); // R8
    st_nxt.pins[10] = (st_nxt.mode != pmv_pkg::PMV_DEEP); // R10 R9
    st_nxt.pins[11] = (st_nxt.mode != pmv_pkg::PMV_DEEP) & osc_source_select; // R10
    st_nxt.pins[12] = ~osc_source_select & ((st_nxt.mode != pmv_pkg::PMV_DEEP) |
                      keep_slow_osc); // R10 R23
    st_nxt.pins[13] = iic_port_on & (st_nxt.mode != pmv_pkg::PMV_DEEP); // R18
    st_nxt.pins[14] = (st_nxt.wdog_cnt != 8'h00); // R16
    st_nxt.pins[15] = st_r.wake_s2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{power_control: pmv_pkg::POWER_CONTROL_RESET, mode: pmv_pkg::PMV_RUN, default: '0}; // R11 R4 R15 R20
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.sfr_rdata   = st_r.rdata;
  assign bus.irq_take    = st_r.take;
  assign bus.irq_src     = st_r.src;
  assign bus.irq_vector  = st_r.vec;
  assign bus.cpu_halt    = st_r.halt;
  assign baud_doubler      = st_r.pins[0];
  assign aux_ram_off       = st_r.pins[1];
  assign ale_run           = st_r.pins[2];
  assign ale_level         = st_r.pins[3];
  assign prog_store_strobe = st_r.pins[4];
  assign port0_float       = st_r.pins[5];
  assign port2_addr        = st_r.pins[6];
  assign timer2_clear      = st_r.pins[7];
  assign pwm_force_high    = st_r.pins[8];
  assign adc_abort         = st_r.pins[9];
  assign sys_clk_run       = st_r.pins[10];
  assign hf_osc_run        = st_r.pins[11];
  assign slow_osc_run      = st_r.pins[12];
  assign iic_pins_allow    = st_r.pins[13];
  assign restart_hold      = st_r.pins[14];
  assign osc_wake          = st_r.pins[15];
endmodule // pmv_device
`default_nettype wire

// ===== verilog/pmv_host.sv
// host end: APB-controlled stand-in for the cpu and interrupt sources
`timescale 1ns/1ps
`default_nettype none
module pmv_host (
  pmv_if.host          bus,
  input  wire logic    pclk,
  input  wire logic    presetn,
  input  wire logic    psel,
  input  wire logic    penable,
  input  wire logic    pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]  prdata,
  output logic         pready,
  output logic         pslverr
);
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wdl;
    logic [14:0] req;
    logic [14:0] lvl;
    logic        isv;
    logic        isv_lvl;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
  } pmv_host_st_t;

  pmv_host_st_t st_r;
  pmv_host_st_t st_nxt;
  logic         setup;

  assign setup = psel & ~penable;

  always_comb begin
    st_nxt = st_r;
    st_nxt.wr = 1'b0;
    st_nxt.wdl = 1'b0;
    st_nxt.ready = 1'b0;
    st_nxt.err = 1'b0;
    if (setup) begin
      // no wait state: answer on the first access cycle
      st_nxt.ready = 1'b1;
      st_nxt.rdata = 32'h0000_0000;
      unique case (paddr)
        pmv_pkg::OFF_CMD: begin
          if (pwrite) begin
            st_nxt.wr    = pwdata[31];
            st_nxt.wdl   = pwdata[30];
            st_nxt.isv   = pwdata[29];
            st_nxt.isv_lvl = pwdata[28];
            st_nxt.addr  = pwdata[15:8];
            st_nxt.wdata = pwdata[7:0];
          end
          st_nxt.rdata = {2'b00, st_r.isv, st_r.isv_lvl, 12'h000, st_r.addr, st_r.wdata};
        end
        pmv_pkg::OFF_STATUS: st_nxt.rdata = {22'h000000, bus.cpu_halt, bus.irq_take,
                                             bus.sfr_rdata};
        pmv_pkg::OFF_VECTOR: st_nxt.rdata = {12'h000, bus.irq_src, bus.irq_vector};
        pmv_pkg::OFF_SRC: begin
          if (pwrite) begin
            st_nxt.req = pwdata[14:0];
            st_nxt.lvl = pwdata[30:16];
          end
          st_nxt.rdata = {1'b0, st_r.lvl, 1'b0, st_r.req};
        end
        default: st_nxt.err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.sfr_wr           = st_r.wr;
  assign bus.sfr_addr         = st_r.addr;
  assign bus.sfr_wdata        = st_r.wdata;
  assign bus.wdog_loaded      = st_r.wdl; // R5
  assign bus.irq_req          = st_r.req;
  assign bus.irq_level        = st_r.lvl;
  assign bus.in_service       = st_r.isv;
  assign bus.in_service_level = st_r.isv_lvl;
  assign prdata  = st_r.rdata;
  assign pready  = st_r.ready;
  assign pslverr = st_r.err;
endmodule // pmv_host
`default_nettype wire

// ===== dv/pmv_chk.sv
// checker: sfr, idle and vectoring timing on the cpu side
`timescale 1ns/1ps
`default_nettype none
module pmv_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        sfr_wr,
  input wire logic [7:0]  sfr_addr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        wdog_loaded,
  input wire logic [14:0] irq_req,
  input wire logic [14:0] irq_level,
  input wire logic        in_service,
  input wire logic        in_service_level,
  input wire logic        irq_take,
  input wire logic [3:0]  irq_src,
  input wire logic [15:0] irq_vector,
  input wire logic        cpu_halt
);
  localparam int ORD [15] = '{0, 5, 10, 1, 6, 11, 2, 7, 12, 3, 8, 13, 4, 9, 14};
  logic [14:0] req_q;
  logic [14:0] lvl_q;
  logic        svc_q;
  logic        svl_q;
  // the take is registered, so it answers to last cycle's inputs
  always_ff @(posedge pclk) begin
    req_q <= irq_req;
    lvl_q <= irq_level;
    svc_q <= in_service;
    svl_q <= in_service_level;
  end
  function automatic logic [3:0] win(logic [14:0] rq, logic [14:0] lv);
    win = 4'hf;
    for (int p = 0; p < 2; p++)
      for (int k = 14; k >= 0; k--)
        if (rq[ORD[k]] && lv[ORD[k]] == p[0]) win = 4'(ORD[k]);
  endfunction
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence power_control_wr;
    sfr_wr && sfr_addr == pmv_pkg::POWER_CONTROL_ADDR;
  endsequence
  sequence power_control_look;
    !sfr_wr && sfr_addr == pmv_pkg::POWER_CONTROL_ADDR;
  endsequence
  vec_map_a: assert property (
    irq_take |-> irq_vector == 16'h0003 + {9'h000, irq_src, 3'h0}) else $error("bad vector");
  take_req_a: assert property (
    irq_take |-> req_q[irq_src]) else $error("take without request");
  fixed_order_a: assert property (
    irq_take && !svc_q |-> irq_src == win(req_q, lvl_q)) else $error("wrong winner");
  svc_block_a: assert property (
    irq_take |-> !svc_q || (!svl_q && lvl_q[irq_src])) else $error("take while blocked");
  rdata_dec_a: assert property (
    sfr_addr != pmv_pkg::POWER_CONTROL_ADDR |=> sfr_rdata == 8'h00) else $error("stray read data");
  permit_clr_a: assert property (
    wdog_loaded && !sfr_wr ##1 power_control_look |=> !sfr_rdata[4]) else $error("permit kept");
  readback_a: assert property (
    power_control_wr ##1 power_control_look |=> {sfr_rdata[7:5], sfr_rdata[3:2]} ==
      $past({sfr_wdata[7:5], sfr_wdata[3:2]}, 2)) else $error("readback differs");
  idle_enter_a: assert property (
    power_control_wr and (sfr_wdata[1:0] == 2'b01 && irq_req == 15'h0) |-> ##[1:4] cpu_halt)
    else $error("idle not entered");
  idle_wake_a: assert property (
    power_control_look and (cpu_halt && sfr_rdata[1:0] == 2'b01 && !in_service &&
      (irq_req & pmv_pkg::IDLE_WAKE_MASK) != 15'h0) |-> ##[1:6] !cpu_halt)
    else $error("idle not ended");
endmodule // pmv_chk
`default_nettype wire

// ===== dv/tb.sv
// testbench: device and host ends joined, driven over apb
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, se;
  logic [11:0] paddr;
  logic [31:0] pwdata, r;
  // di: wdog-off, wdog-rst, hf-sel, keep-slow, iic-on, ext-mem, pins a b,
  // levels a b, enables a b, tick
  logic [12:0] di;
  logic [1:0]  sv;
  logic [14:0] q, l;
  logic [7:0]  d;
  wire  [31:0] prdata;
  wire         pready, pslverr;
  wire  [15:0] o;
  int          miscompares, n_checks, i, seed;
  int          cyc = 0;
  localparam int ORD [15] = '{0, 5, 10, 1, 6, 11, 2, 7, 12, 3, 8, 13, 4, 9, 14};
  // 1 us of reset at 25 ns per clock
  localparam int PLL_RESET_CLKS = 40;
  always #12.5 pclk = ~pclk;
  pmv_if bus (.pclk(pclk), .presetn(presetn));
  pmv_device u_pmv_device (.bus(bus), .pclk(pclk), .presetn(presetn),
    .watchdog_off_pin(di[0]), .wdog_reset(di[1]), .osc_source_select(di[2]),
    .keep_slow_osc(di[3]), .iic_port_on(di[4]), .ext_mem(di[5]), .ext_a_pin(di[6]),
    .ext_b_pin(di[7]), .ext_a_level(di[8]), .ext_b_level(di[9]), .ext_a_en(di[10]),
    .ext_b_en(di[11]), .tick_req(di[12]), .baud_doubler(o[0]), .aux_ram_off(o[1]),
    .ale_run(o[2]), .ale_level(o[3]), .prog_store_strobe(o[4]), .port0_float(o[5]),
    .port2_addr(o[6]), .timer2_clear(o[7]), .pwm_force_high(o[8]), .adc_abort(o[9]),
    .sys_clk_run(o[10]), .hf_osc_run(o[11]), .slow_osc_run(o[12]),
    .iic_pins_allow(o[13]), .restart_hold(o[14]), .osc_wake(o[15]));
  pmv_host u_pmv_host (.bus(bus), .pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  pmv_chk u_pmv_chk (.pclk(pclk), .presetn(presetn), .sfr_wr(bus.sfr_wr),
    .sfr_addr(bus.sfr_addr), .sfr_wdata(bus.sfr_wdata), .sfr_rdata(bus.sfr_rdata),
    .wdog_loaded(bus.wdog_loaded), .irq_req(bus.irq_req), .irq_level(bus.irq_level),
    .in_service(bus.in_service), .in_service_level(bus.in_service_level),
    .irq_take(bus.irq_take), .irq_src(bus.irq_src), .irq_vector(bus.irq_vector),
    .cpu_halt(bus.cpu_halt));
  function automatic logic [3:0] win(logic [14:0] rq, logic [14:0] lv);
    win = 4'hf;
    for (int p = 0; p < 2; p++)
      for (int k = 14; k >= 0; k--)
        if (rq[ORD[k]] && lv[ORD[k]] == p[0]) win = 4'(ORD[k]);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) miscompares++;
    r = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // service bits ride along so every command keeps them
  task automatic cmd(input logic [31:0] c);
    apb(1'b1, pmv_pkg::OFF_CMD, c | {2'b00, sv, 28'h0});
    repeat (4) @(posedge pclk);
  endtask
  task automatic src(input logic [14:0] rq, input logic [14:0] lv);
    apb(1'b1, pmv_pkg::OFF_SRC, {1'b0, lv, 1'b0, rq});
    repeat (4) @(posedge pclk);
  endtask
  task automatic st;
    apb(1'b0, pmv_pkg::OFF_STATUS, 32'h0);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    seed = 32'hcdff;
    {presetn, psel, penable, pwrite, paddr, pwdata, sv} = '0;
    di = 13'h0fc4;
    miscompares = 0;
    n_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmd(32'h0000_8700);
    st();
    chk(32'(r[7:0]), 32'(pmv_pkg::POWER_CONTROL_RESET));
    apb(1'b0, 12'h010, 32'h0);
    chk(32'(se), 32'h1);
    for (i = 0; i < 8; i++) begin
      d = 8'($random(seed)) & 8'hfc;
      cmd({16'h8000, 8'h87, d});
      st();
      chk(32'(r[7:0]), 32'(d));
      chk(32'(o[2:0]), {29'h0, ~d[5], d[6], d[7]});
    end
    cmd(32'h0000_8600);
    st();
    chk(32'(r[7:0]), 32'h0);
    cmd(32'h8000_8710);
    cmd(32'h4000_8700);
    st();
    chk(32'(r[7:0]), 32'h0);
    $display("register test done");
    for (i = 0; i < 15; i++) begin
      src(15'h0, 15'h0);
      src(15'(1 << i), 15'h0);
      apb(1'b0, pmv_pkg::OFF_VECTOR, 32'h0);
      chk(r, {12'h0, 4'(i), 16'h0003 + 16'(8 * i)});
    end
    for (i = 0; i < 12; i++) begin
      q = 15'($random(seed)) | 15'h0100;
      l = 15'($random(seed));
      if (i < 2) begin
        q = 15'h7fff << i;
        l = 15'h0;
      end
      src(15'h0, 15'h0);
      src(q, l);
      apb(1'b0, pmv_pkg::OFF_VECTOR, 32'h0);
      chk(32'(r[19:16]), 32'(win(q, l)));
    end
    src(15'h0, 15'h0);
    $display("vector test done");
    di[5:4] <= 2'b11;
    cmd(32'h8000_8701);
    st();
    chk(32'(r[9]), 32'h1);
    chk(32'(o & 16'h27fc), 32'h27f8);
    src(15'h0040, 15'h0);
    st();
    chk(32'(r[9]), 32'h1);
    src(15'h0042, 15'h0);
    st();
    // take keeps standing while the timer request is still raised
    chk(32'(r[9:0]), 32'h100);
    apb(1'b0, pmv_pkg::OFF_VECTOR, 32'h0);
    chk(32'(r[19:0]), 32'h1000b);
    src(15'h0, 15'h0);
    sv = 2'b11;
    cmd(32'h8000_8701);
    src(15'h0002, 15'h0002);
    st();
    chk(32'(r[9]), 32'h1);
    sv = 2'b00;
    cmd(32'h0000_8700);
    st();
    chk(32'(r[9]), 32'h0);
    src(15'h0, 15'h0);
    $display("idle test done");
    di[0] <= 1'b0;
    cmd(32'h8000_8702);
    st();
    chk(32'(r[9:0]), 32'h0);
    di[3:0] <= 4'b1001;
    cmd(32'h8000_8702);
    st();
    chk(32'({r[9], r[1:0]}), 32'h6);
    chk(32'(o & 16'h3d7c), 32'h1120);
    di[6] <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(32'(o[15]), 32'h1);
    di[6] <= 1'b1;
    st();
    chk(32'({r[9], r[1:0]}), 32'h0);
    sv = 2'b11;
    cmd(32'h8000_8702);
    di[7] <= 1'b0;
    repeat (8) @(posedge pclk);
    di[7] <= 1'b1;
    st();
    chk(32'({r[9], r[1:0]}), 32'h5);
    sv = 2'b00;
    cmd(32'h0000_8700);
    src(15'h0001, 15'h0001);
    st();
    chk(32'(r[9]), 32'h0);
    src(15'h0, 15'h0);
    $display("power-down test done");
    cmd(32'h8000_8701);
    di[1] <= 1'b1;
    @(posedge pclk);
    di[1] <= 1'b0;
    repeat (20) @(posedge pclk);
    chk(32'(o[14]), 32'h1);
    repeat (24) @(posedge pclk);
    chk(32'(o[14]), 32'h0);
    st();
    chk(32'(r[9]), 32'h0);
    $display("watchdog test done");
    di[2] <= 1'b1;
    cmd(32'h8000_8721);
    presetn <= 1'b0;
    repeat (pmv_pkg::EXT_RESET_MIN_CLKS) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmd(32'h0000_8700);
    st();
    chk(32'({o[2], r[9:0]}), 32'h400);
    di[2] <= 1'b0;
    cmd(32'h8000_8702);
    presetn <= 1'b0;
    repeat (PLL_RESET_CLKS) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmd(32'h0000_8700);
    st();
    chk(32'({o[10], r[9:0]}), 32'h400);
    $display("reset test done");
    end_sim();
  end
endmodule // tb
`default_nettype wire
